//--- rtl/repeater_cfg_pkg.sv
// Constants shared by the repeater configuration device and its controller
// What this block does
// - Image header: flags plus four-bit highest device index
// - One pointer byte per device, sharing allowed
// - Block holds map offsets 3..39, 37 bytes
// - Register 0x00 bits 6:3 show straps
// - Register 0x00 bit 2 flags load done
// - Register 0x01 powers channels down individually
// - Register power-down beats presence pin
// - 0x02 bit 7 lets bit 6 drive detect reset
// - 0x02 bit 0 makes presence pin ignored
// - 0x06 bit 3 enables register control
// - 0x07 bit 6 restores defaults, self-clears
package repeater_cfg_pkg;

    // ----------------------------------------
    // Device register map
    // ----------------------------------------
    localparam logic [7:0] REG_STRAP     = 8'h00;
    localparam logic [7:0] REG_PWDN      = 8'h01;
    localparam logic [7:0] REG_PRESENCE  = 8'h02;
    localparam logic [7:0] REG_SLAVE     = 8'h06;
    localparam logic [7:0] REG_DRESET    = 8'h07;
    localparam logic [7:0] REG_LAST      = 8'h07;
    localparam int         NUM_REGS      = 8;

    localparam logic [7:0] RST_STRAP     = 8'h00;
    localparam logic [7:0] RST_PWDN      = 8'h00;
    localparam logic [7:0] RST_PRESENCE  = 8'h00;
    localparam logic [7:0] RST_RSVD      = 8'h00;
    localparam logic [7:0] RST_SLAVE     = 8'h10;
    localparam logic [7:0] RST_DRESET    = 8'h01;
    localparam logic [NUM_REGS-1:0][7:0] REG_DEFAULTS = {RST_DRESET, RST_SLAVE, RST_RSVD,
        RST_RSVD, RST_RSVD, RST_PRESENCE, RST_PWDN, RST_STRAP};

    localparam logic [7:0] STRAP_RW_MASK = 8'h83;
    localparam int         STRAP_LSB     = 3;
    localparam int         STRAP_MSB     = 6;
    localparam int         LOAD_DONE_BIT = 2;
    localparam int         OVR_RECEIVER_DETECT_BIT = 7;
    localparam int         RECEIVER_DETECT_VAL_BIT = 6;
    localparam int         OVR_PRES_BIT  = 0;
    localparam int         REG_EN_BIT    = 3;
    localparam int         REG_RESET_BIT = 6;

    // ----------------------------------------
    // Configuration image layout
    // ----------------------------------------
    localparam logic [7:0] EE_HDR_ADDR   = 8'h00;
    localparam logic [7:0] EE_PTR_BASE   = 8'h04;
    localparam int         HDR_CRC_BIT   = 7;
    localparam int         HDR_MAP_BIT   = 6;
    localparam int         HDR_BIG_BIT   = 5;
    localparam int         HDR_CNT_MSB   = 3;
    localparam logic [5:0] BLOCK_FIRST   = 6'd3;
    localparam logic [5:0] BLOCK_LAST    = 6'd39;
    localparam logic [5:0] BLOCK_LEN     = BLOCK_LAST - BLOCK_FIRST + 6'd1;

    // ----------------------------------------
    // Controller registers (Avalon byte addresses)
    // ----------------------------------------
    localparam logic [4:0] AV_CMD        = 5'h00;
    localparam logic [4:0] AV_STATUS     = 5'h04;
    localparam logic [4:0] AV_IRQ        = 5'h08;
    localparam logic [4:0] AV_MASK       = 5'h0C;
    localparam logic [4:0] AV_IMAGE      = 5'h10;
    localparam int         CMD_GO_BIT    = 0;
    localparam int         CMD_WE_BIT    = 1;
    localparam int         CMD_ADDR_LSB  = 8;
    localparam int         CMD_DATA_LSB  = 16;
    localparam int         IMG_ADDR_LSB  = 8;
    localparam int         STAT_BUSY_BIT = 0;
    localparam int         STAT_DATA_LSB = 8;
    localparam int         NUM_EVENTS    = 2;
    localparam int         EV_DONE       = 0;
    localparam int         EV_FETCH      = 1;

endpackage

//--- rtl/repeater_link_if.sv
// Link between the repeater configuration device and its controller
`timescale 1ns/1ps
`default_nettype none
interface repeater_link_if (
    input wire logic clk_i,
    input wire logic resetn_i
);
    // Register access, request held until ack pulse
    logic       reg_req;
    logic       reg_we;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_ack;
    // Image fetch, request held until ack pulse
    logic       ee_req;
    logic [7:0] ee_addr;
    logic [7:0] ee_data;
    logic       ee_ack;

    modport device (
        input  clk_i, resetn_i, reg_req, reg_we, reg_addr, reg_wdata, ee_data, ee_ack,
        output reg_rdata, reg_ack, ee_req, ee_addr
    );
    modport controller (
        input  clk_i, resetn_i, reg_rdata, reg_ack, ee_req, ee_addr,
        output reg_req, reg_we, reg_addr, reg_wdata, ee_data, ee_ack
    );
endinterface
`default_nettype wire

//--- rtl/sticky_irq_bank.sv
// Sticky event bits with write-one-to-clear, mask and one interrupt line
`timescale 1ns/1ps
`default_nettype none
module sticky_irq_bank #(
    parameter int N = 2
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Events and software access
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clear_i,
    input  wire logic         mask_we_i,
    input  wire logic [N-1:0] mask_i,
    // State
    output logic      [N-1:0] status_o,
    output logic      [N-1:0] mask_o,
    output logic              irq_o
);
    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
        logic         irq;
    } irq_s;

    irq_s s_q;
    irq_s s_d;

    always_comb begin
        s_d = s_q;
        // Set wins over a clear in the same cycle
        s_d.status = (s_q.status & ~clear_i) | set_i;
        if (mask_we_i) begin
            s_d.mask = mask_i;
        end
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign status_o = s_q.status;
    assign mask_o   = s_q.mask;
    assign irq_o    = s_q.irq;
endmodule // sticky_irq_bank
`default_nettype wire

//--- rtl/repeater_cfg_device.sv
// Configuration register bank and image loader of the repeater
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module repeater_cfg_device
    import repeater_cfg_pkg::*;
(
    // Link to the controller
    repeater_link_if.device link,

    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,

    // Pins
    input  wire logic [3:0] strap_i,
    input  wire logic       presence_detect_pin_i,
    input  wire logic       receiver_detect_auto_reset_i,

    // Channel control
    output logic      [7:0] channel_off_o,
    output logic            receiver_detect_reset_o,
    output logic            register_control_o,
    output logic            load_done_o,

    // Loaded configuration bytes
    output logic            cfg_valid_o,
    output logic      [5:0] cfg_offset_o,
    output logic      [7:0] cfg_byte_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        LD_HEADER,
        LD_POINTER,
        LD_BLOCK,
        LD_DONE
    } load_e;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic [3:0]               strap;
        logic                     strap_taken;
        logic                     load_done;
        load_e                    ld;
        logic [7:0]               block_ptr;
        logic [5:0]               ld_cnt;
        logic                     ee_req;
        logic [7:0]               ee_addr;
        logic                     reg_ack;
        logic [7:0]               reg_rdata;
        logic [7:0]               chan_off;
        logic                     receiver_detect_reset;
        logic                     reg_ctrl;
        logic                     cfg_valid;
        logic [5:0]               cfg_offset;
        logic [7:0]               cfg_byte;
    } dev_s;

    localparam dev_s DEV_RESET = '{regs: REG_DEFAULTS, ld: LD_HEADER, default: '0};

    dev_s s_q;
    dev_s s_d;

    // ----------------------------------------
    // Read view of one register
    // ----------------------------------------
    function automatic logic [7:0] read_view(input dev_s s, input logic [2:0] idx);
        logic [7:0] v;
        v = s.regs[idx];
        if (idx == REG_STRAP[2:0]) begin
            v = s.regs[idx] & STRAP_RW_MASK;
            v[STRAP_MSB:STRAP_LSB] = s.strap;
            v[LOAD_DONE_BIT] = s.load_done;
        end
        return v;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [2:0] idx;
        logic       hit;
        logic [7:0] ptr_addr;
        idx      = link.reg_addr[2:0];
        hit      = (link.reg_addr <= REG_LAST);
        ptr_addr = EE_PTR_BASE + {3'b000, s_q.strap, 1'b0};
        s_d = s_q;
        s_d.reg_ack   = 1'b0;
        s_d.cfg_valid = 1'b0;

        // Straps caught once, after reset release
        if (!s_q.strap_taken) begin
            s_d.strap       = strap_i;
            s_d.strap_taken = 1'b1;
        end

        // Self-clearing register reset
        if (s_q.regs[REG_DRESET[2:0]][REG_RESET_BIT]) begin
            s_d.regs = REG_DEFAULTS;
        end

        // Register access from the link
        if (link.reg_req && !s_q.reg_ack) begin
            s_d.reg_ack   = 1'b1;
            s_d.reg_rdata = hit ? read_view(s_q, idx) : 8'h00;
            if (link.reg_we && hit) begin
                if (idx == REG_STRAP[2:0]) begin
                    s_d.regs[idx] = link.reg_wdata & STRAP_RW_MASK;
                end else begin
                    s_d.regs[idx] = link.reg_wdata;
                end
            end
        end

        // Image loader
        if (s_q.ee_req) begin
            if (link.ee_ack) begin
                s_d.ee_req = 1'b0;
                unique case (s_q.ld)
                    LD_HEADER: begin
                        // Count field is the highest device index
                        if (s_q.strap > link.ee_data[HDR_CNT_MSB:0]) begin
                            s_d.ld        = LD_DONE;
                            s_d.load_done = 1'b1;
                        end else begin
                            s_d.ld = LD_POINTER;
                        end
                    end
                    LD_POINTER: begin
                        s_d.block_ptr = link.ee_data;
                        s_d.ld_cnt    = 6'h00;
                        s_d.ld        = LD_BLOCK;
                    end
                    LD_BLOCK: begin
                        s_d.cfg_valid  = 1'b1;
                        s_d.cfg_offset = BLOCK_FIRST + s_q.ld_cnt;
                        s_d.cfg_byte   = link.ee_data;
                        s_d.ld_cnt     = s_q.ld_cnt + 6'd1;
                        if (s_q.ld_cnt == BLOCK_LEN - 6'd1) begin
                            s_d.ld        = LD_DONE;
                            s_d.load_done = 1'b1;
                        end
                    end
                    LD_DONE: begin
                    end
                endcase
            end
        end else begin
            unique case (s_q.ld)
                LD_HEADER: begin
                    if (s_q.strap_taken) begin
                        s_d.ee_req  = 1'b1;
                        s_d.ee_addr = EE_HDR_ADDR;
                    end
                end
                LD_POINTER: begin
                    s_d.ee_req  = 1'b1;
                    s_d.ee_addr = ptr_addr;
                end
                LD_BLOCK: begin
                    s_d.ee_req  = 1'b1;
                    s_d.ee_addr = s_q.block_ptr + {2'b00, s_q.ld_cnt};
                end
                LD_DONE: begin
                end
            endcase
        end

        // Channel control from the registers
        s_d.chan_off = s_q.regs[REG_PWDN[2:0]];
        if (!s_q.regs[REG_PRESENCE[2:0]][OVR_PRES_BIT]) begin
            s_d.chan_off = s_d.chan_off | {8{!presence_detect_pin_i}};
        end
        if (s_q.regs[REG_PRESENCE[2:0]][OVR_RECEIVER_DETECT_BIT]) begin
            s_d.receiver_detect_reset = s_q.regs[REG_PRESENCE[2:0]][RECEIVER_DETECT_VAL_BIT];
        end else begin
            s_d.receiver_detect_reset = receiver_detect_auto_reset_i;
        end
        s_d.reg_ctrl = s_q.regs[REG_SLAVE[2:0]][REG_EN_BIT];
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= DEV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.reg_rdata          = s_q.reg_rdata;
    assign link.reg_ack            = s_q.reg_ack;
    assign link.ee_req             = s_q.ee_req;
    assign link.ee_addr            = s_q.ee_addr;
    assign channel_off_o           = s_q.chan_off;
    assign receiver_detect_reset_o = s_q.receiver_detect_reset;
    assign register_control_o      = s_q.reg_ctrl;
    assign load_done_o             = s_q.load_done;
    assign cfg_valid_o             = s_q.cfg_valid;
    assign cfg_offset_o            = s_q.cfg_offset;
    assign cfg_byte_o              = s_q.cfg_byte;

endmodule // repeater_cfg_device
`default_nettype wire

//--- rtl/repeater_cfg_controller.sv
// Controller end: Avalon-MM slave, register access master and image store
`timescale 1ns/1ps
`default_nettype none
module repeater_cfg_controller
    import repeater_cfg_pkg::*;
(
    // Link to the device
    repeater_link_if.controller link,

    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,

    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,

    // Interrupt
    output logic             irq_o
);

    typedef struct packed {
        logic        av_ack;
        logic [31:0] rdata;
        logic        busy;
        logic        reg_req;
        logic        reg_we;
        logic [7:0]  reg_addr;
        logic [7:0]  reg_wdata;
        logic [7:0]  reg_result;
        logic        ee_ack;
        logic [7:0]  ee_data;
        logic [NUM_EVENTS-1:0] events;
    } ctl_s;

    ctl_s s_q;
    ctl_s s_d;

    logic [7:0]            image_mem [256];
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [NUM_EVENTS-1:0] irq_clear;
    logic                  mask_we;
    logic                  commit;

    // Write takes effect at the edge where waitrequest is sampled low
    assign commit    = avs_write_i && s_q.av_ack;
    assign irq_clear = (commit && avs_address_i == AV_IRQ)
                     ? avs_writedata_i[NUM_EVENTS-1:0] : '0;
    assign mask_we   = commit && avs_address_i == AV_MASK;

    sticky_irq_bank #(.N(NUM_EVENTS)) u_irq (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .set_i     (s_q.events),
        .clear_i   (irq_clear),
        .mask_we_i (mask_we),
        .mask_i    (avs_writedata_i[NUM_EVENTS-1:0]),
        .status_o  (irq_status),
        .mask_o    (irq_mask),
        .irq_o     (irq_o)
    );

    // ----------------------------------------
    // Image store, served to the device
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (commit && avs_address_i == AV_IMAGE) begin
            image_mem[avs_writedata_i[IMG_ADDR_LSB +: 8]] <= avs_writedata_i[7:0];
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.events = '0;
        s_d.av_ack = (avs_read_i || avs_write_i) && !s_q.av_ack;
        if (avs_read_i && !s_q.av_ack) begin
            s_d.rdata = 32'h0000_0000;
            unique case (avs_address_i)
                AV_STATUS: begin
                    s_d.rdata[STAT_BUSY_BIT] = s_q.busy;
                    s_d.rdata[STAT_DATA_LSB +: 8] = s_q.reg_result;
                end
                AV_IRQ:  s_d.rdata[NUM_EVENTS-1:0] = irq_status;
                AV_MASK: s_d.rdata[NUM_EVENTS-1:0] = irq_mask;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // Command accepted only while idle
        if (commit && avs_address_i == AV_CMD && !s_q.busy
                && avs_writedata_i[CMD_GO_BIT]) begin
            s_d.busy      = 1'b1;
            s_d.reg_req   = 1'b1;
            s_d.reg_we    = avs_writedata_i[CMD_WE_BIT];
            s_d.reg_addr  = avs_writedata_i[CMD_ADDR_LSB +: 8];
            s_d.reg_wdata = avs_writedata_i[CMD_DATA_LSB +: 8];
        end
        if (s_q.reg_req && link.reg_ack) begin
            s_d.reg_req    = 1'b0;
            s_d.busy       = 1'b0;
            s_d.reg_result = link.reg_rdata;
            s_d.events[EV_DONE] = 1'b1;
        end
        s_d.ee_ack = link.ee_req && !s_q.ee_ack;
        if (link.ee_req && !s_q.ee_ack) begin
            s_d.ee_data = image_mem[link.ee_addr];
            s_d.events[EV_FETCH] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_o    = s_q.rdata;
    assign avs_waitrequest_o = !s_q.av_ack;
    assign link.reg_req      = s_q.reg_req;
    assign link.reg_we       = s_q.reg_we;
    assign link.reg_addr     = s_q.reg_addr;
    assign link.reg_wdata    = s_q.reg_wdata;
    assign link.ee_ack       = s_q.ee_ack;
    assign link.ee_data      = s_q.ee_data;

endmodule // repeater_cfg_controller
`default_nettype wire

//--- tb/repeater_link_checker.sv
// Assertions on the link between the repeater device and its controller
`timescale 1ns/1ps
`default_nettype none
module repeater_link_checker
    import repeater_cfg_pkg::*;
(
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       resetn_i,
    // Register access
    input wire logic       reg_req,
    input wire logic       reg_we,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_ack,
    // Image fetch
    input wire logic       ee_req,
    input wire logic [7:0] ee_addr,
    input wire logic [7:0] ee_data,
    input wire logic       ee_ack
);
    // ----------------------------------------
    // Handshake sequences and properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_reg_take;
        reg_req && !reg_ack;
    endsequence
    sequence s_ee_take;
        ee_req && !ee_ack;
    endsequence
    sequence s_hdr_done;
        ee_ack && ee_addr == EE_HDR_ADDR;
    endsequence

    property p_reg_answer; s_reg_take |=> reg_ack; endproperty
    a_reg_answer: assert property (p_reg_answer) else $error("access not answered");
    property p_reg_pulse; reg_ack |=> !reg_ack; endproperty
    a_reg_pulse: assert property (p_reg_pulse) else $error("ack longer than one cycle");
    property p_reg_hold;
        s_reg_take |=> $stable(reg_addr) && $stable(reg_we) && $stable(reg_wdata);
    endproperty
    a_reg_hold: assert property (p_reg_hold) else $error("request changed while open");
    property p_req_drop; reg_ack |=> !reg_req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
    property p_rdata_hold; !$stable(reg_rdata) |-> reg_ack; endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without ack");
    property p_ack_cause; reg_ack |-> $past(reg_req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ee_answer; s_ee_take |=> ee_ack && $stable(ee_addr); endproperty
    a_ee_answer: assert property (p_ee_answer) else $error("fetch not answered");
    property p_ee_gap; ee_ack |=> !ee_req && !ee_ack; endproperty
    a_ee_gap: assert property (p_ee_gap) else $error("no idle cycle after fetch");
    property p_hdr_next;
        s_hdr_done |-> ##2 (!ee_req || (!ee_addr[0] && ee_addr >= EE_PTR_BASE));
    endproperty
    a_hdr_next: assert property (p_hdr_next) else $error("no pointer fetch after header");
endmodule // repeater_link_checker
`default_nettype wire

//--- tb/repeater_config_register_bank_test.sv
// Self-checking bench for the repeater configuration device and controller
`timescale 1ns/1ps
`default_nettype none
module repeater_config_register_bank_test import repeater_cfg_pkg::*;;
    logic        clk_i;
    logic        resetn_i;
    logic [3:0]  strap_i;
    logic        presence_pin;
    logic        auto_rst;
    logic [7:0]  channel_off;
    logic        receiver_detect_rst;
    logic        reg_ctl;
    logic        load_done;
    logic        cfg_valid;
    logic [5:0]  cfg_offset;
    logic [7:0]  cfg_byte;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic [7:0]  img [0:84];
    logic [31:0] rnd;
    logic [31:0] rd;
    logic [7:0]  pw;
    int          n_mismatch;
    int          comparisons;
    int          n_cfg;
    int          ptr;

    repeater_link_if u_repeater_link_if (.clk_i(clk_i), .resetn_i(resetn_i));
    repeater_cfg_device u_repeater_cfg_device (.link(u_repeater_link_if.device),
        .clk_i(clk_i), .resetn_i(resetn_i), .strap_i(strap_i),
        .presence_detect_pin_i(presence_pin), .receiver_detect_auto_reset_i(auto_rst),
        .channel_off_o(channel_off), .receiver_detect_reset_o(receiver_detect_rst),
        .register_control_o(reg_ctl), .load_done_o(load_done), .cfg_valid_o(cfg_valid),
        .cfg_offset_o(cfg_offset), .cfg_byte_o(cfg_byte));
    repeater_cfg_controller u_repeater_cfg_controller (.link(u_repeater_link_if.controller),
        .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .irq_o(irq));
    repeater_link_checker u_repeater_link_checker (.clk_i(clk_i), .resetn_i(resetn_i),
        .reg_req(u_repeater_link_if.reg_req), .reg_we(u_repeater_link_if.reg_we),
        .reg_addr(u_repeater_link_if.reg_addr), .reg_wdata(u_repeater_link_if.reg_wdata),
        .reg_rdata(u_repeater_link_if.reg_rdata), .reg_ack(u_repeater_link_if.reg_ack),
        .ee_req(u_repeater_link_if.ee_req), .ee_addr(u_repeater_link_if.ee_addr),
        .ee_data(u_repeater_link_if.ee_data), .ee_ack(u_repeater_link_if.ee_ack));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    function automatic logic [7:0] exp_off(input logic [7:0] p, input logic ovr, input logic pin);
        return p | {8{!ovr && !pin}};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic av(input logic [4:0] a, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        @(posedge clk_i);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin
                n_mismatch++;
                conclude();
            end
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic dev(input logic [7:0] a, input logic we, input logic [7:0] d);
        int n;
        av(AV_CMD, 1'b1, {8'h00, d, a, 6'h00, we, 1'b1});
        n = 0;
        do begin
            av(AV_STATUS, 1'b0, 32'h0000_0000);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 20);
        check(rd[STAT_BUSY_BIT], 1'b0);
        if (rd[STAT_BUSY_BIT] !== 1'b0) conclude();
    endtask

    task automatic restart(input int s);
        int n;
        resetn_i <= 1'b0;
        strap_i <= s[3:0];
        n_cfg = 0;
        ptr = (s <= 3) ? int'(img[4 + 2 * s]) : 0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        n = 0;
        while (load_done !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        check(n_cfg, (s <= 3) ? 37 : 0);
        check(load_done, 1'b1);
        if (load_done !== 1'b1) conclude();
    endtask

    always @(posedge clk_i) begin
        if (cfg_valid === 1'b1 && ptr >= 0) begin
            check(cfg_offset, BLOCK_FIRST + n_cfg);
            check(cfg_byte, img[ptr + n_cfg]);
            n_cfg++;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        resetn_i = 1'b0;
        strap_i = 4'h2;
        presence_pin = 1'b1;
        auto_rst = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        rnd = 32'h0000_8966;
        n_mismatch = 0;
        comparisons = 0;
        n_cfg = 0;
        ptr = -1;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 85; i++) begin
            rnd = xorshift(rnd);
            img[i] = (i == 0) ? 8'h43 : rnd[7:0];
            if (i >= 4 && i <= 10 && !i[0])
                img[i] = (i < 8) ? 8'h0B : 8'h30;
            av(AV_IMAGE, 1'b1, {16'h0000, i[7:0], img[i]});
        end
        for (int s = 0; s < 5; s++) begin
            restart(s == 4 ? 5 : s);
            dev(REG_STRAP, 1'b0, 8'h00);
            check(rd[15:8], {1'b0, strap_i, 1'b1, 2'b00});
        end
        $display("test image load done");
        for (int a = 1; a < 9; a++) begin
            rnd = xorshift(rnd);
            pw = rnd[7:0] & (a == 1 ? 8'hFF : a == 2 ? 8'hC1 : a == 6 ? 8'h08 : 8'h00);
            pw = pw | (a == 6 ? 8'h10 : a == 7 ? 8'h01 : 8'h00);
            dev(a[7:0], 1'b1, pw);
            dev(a[7:0], 1'b0, 8'h00);
            check(rd[15:8], (a == 8) ? 8'h00 : pw);
        end
        for (int k = 0; k < 8; k++) begin
            rnd = xorshift(rnd);
            pw = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rnd[7:0];
            presence_pin <= rnd[8];
            auto_rst <= rnd[9];
            dev(REG_PWDN, 1'b1, pw);
            dev(REG_PRESENCE, 1'b1, {rnd[11:10], 5'b0_0000, rnd[12]});
            dev(REG_SLAVE, 1'b1, {4'h1, rnd[13], 3'h0});
            check(channel_off, exp_off(pw, rnd[12], rnd[8]));
            check(receiver_detect_rst, rnd[11] ? rnd[10] : rnd[9]);
            check(reg_ctl, rnd[13]);
        end
        $display("test channel control done");
        dev(REG_DRESET, 1'b1, 8'h41);
        for (int a = 1; a < 8; a++) begin
            dev(a[7:0], 1'b0, 8'h00);
            check(rd[15:8], (a == 6) ? 8'h10 : (a == 7) ? 8'h01 : 8'h00);
        end
        dev(REG_STRAP, 1'b1, 8'h7C);
        dev(REG_STRAP, 1'b0, 8'h00);
        check(rd[15:8], {1'b0, strap_i, 3'b100});
        $display("test register reset done");
        av(AV_IRQ, 1'b1, 32'h0000_0003);
        av(AV_MASK, 1'b1, 32'h0000_0001);
        dev(REG_PWDN, 1'b0, 8'h00);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b1);
        av(AV_IRQ, 1'b1, 32'h0000_0001);
        @(posedge clk_i);
        check(irq, 1'b0);
        av(AV_MASK, 1'b1, 32'h0000_0000);
        dev(REG_PWDN, 1'b0, 8'h00);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b0);
        av(AV_IRQ, 1'b0, 32'h0000_0000);
        check(rd[1:0], 2'b01);
        av(5'h14, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        $display("test interrupt done");
        conclude();
    end
endmodule // repeater_config_register_bank_test
`default_nettype wire
